// [hdl/mms_pkg.sv]
// Constants for the memory-map decoder and operating-mode latch
package mms_pkg;

   // ******************************************************************
   // Register offsets on the register port
   // ******************************************************************
   localparam logic [15:0] PRIO_MISC_OFS = 16'h103c;
   localparam logic [15:0] MAP_INIT_OFS = 16'h103d;
   localparam logic [15:0] CONFIG_OFS = 16'h103f;

   // ******************************************************************
   // Field positions and reset values
   // ******************************************************************
   localparam int PM_BOOT_BIT = 7;
   localparam int PM_SPEC_BIT = 6;
   localparam int PM_MODE_A_BIT = 5;
   localparam int PM_VIS_BIT = 4;
   localparam int PM_PSEL_LSB = 0;
   localparam logic [3:0] PSEL_RST = 4'h6;
   localparam logic [7:0] MAP_INIT_RST = 8'h01;
   localparam int INIT_RAM_LSB = 4;
   localparam int INIT_REG_LSB = 0;
   localparam int CFG_EE_LSB = 4;
   localparam int CFG_ROM_BIT = 1;
   localparam int CFG_EEON_BIT = 0;

   // ******************************************************************
   // Reset vectors and fixed windows
   // ******************************************************************
   localparam logic [15:0] VEC_NORMAL = 16'hfffa;
   localparam logic [15:0] VEC_SPECIAL = 16'hbffa;
   localparam logic [15:0] BOOT_BASE = 16'hbf00;
   localparam logic [16:0] BOOT_SIZE = 17'h00100;
   localparam logic [15:0] EE_SMALL_BASE = 16'hb600;
   localparam logic [16:0] EE_SMALL_SIZE = 17'h00200;
   localparam logic [11:0] EE_LARGE_OFS = 12'h800;
   localparam logic [16:0] EE_LARGE_SIZE = 17'h00800;
   localparam logic [16:0] REG_SIZE = 17'h00040;
   localparam logic [16:0] RAM_SIZE_DEF = 17'h00200;
   localparam logic [15:0] ROM_BASE_DEF = 16'hd000;

   // ******************************************************************
   // Resource select positions, highest rank first
   // ******************************************************************
   localparam int SEL_REG = 0;
   localparam int SEL_RAM = 1;
   localparam int SEL_BOOT = 2;
   localparam int SEL_EE = 3;
   localparam int SEL_ROM = 4;
   localparam int SEL_EXT = 5;
   localparam int NUM_RES = 6;

endpackage : mms_pkg

// [hdl/mms_decode.sv]
// Combinational address decoder with fixed resource ranking
`timescale 1ns/10ps
`default_nettype none

module mms_decode #(
   parameter bit EE_LARGE = 1'b0,
   parameter logic [16:0] RAM_SIZE = mms_pkg::RAM_SIZE_DEF,
   parameter logic [15:0] ROM_BASE = mms_pkg::ROM_BASE_DEF
) (
   input wire logic [15:0] addr_in,      // Core address
   input wire logic [3:0] ram_blk_in,    // RAM 4K block
   input wire logic [3:0] reg_blk_in,    // Register block 4K block
   input wire logic boot_en_in,          // Boot ROM in map
   input wire logic eeon_in,             // EEPROM in map
   input wire logic rom_en_in,           // Program ROM in map
   input wire logic [3:0] ee_map_in,     // EEPROM 4K block, large part
   output logic [mms_pkg::NUM_RES-1:0] hit_out, // Raw window hits
   output logic [mms_pkg::NUM_RES-1:0] sel_out  // One-hot winner
);

   // ******************************************************************
   // Window test
   // ******************************************************************
   function automatic logic in_win(input logic [15:0] a, input logic [15:0] base,
                                   input logic [16:0] size);
      logic [16:0] top;
      top = {1'b0, base} + size;
      return ({1'b0, a} >= {1'b0, base}) && ({1'b0, a} < top);
   endfunction : in_win

   // ******************************************************************
   // Hits and ranking
   // ******************************************************************
   always_comb begin
      logic found;
      found = 1'b0;
      hit_out = '0;
      hit_out[mms_pkg::SEL_REG] = in_win(addr_in, {reg_blk_in, 12'h000}, mms_pkg::REG_SIZE);
      hit_out[mms_pkg::SEL_RAM] = in_win(addr_in, {ram_blk_in, 12'h000}, RAM_SIZE);
      hit_out[mms_pkg::SEL_BOOT] = boot_en_in &&
         in_win(addr_in, mms_pkg::BOOT_BASE, mms_pkg::BOOT_SIZE);
      if (EE_LARGE) begin
         hit_out[mms_pkg::SEL_EE] = eeon_in && in_win(addr_in,
            {ee_map_in, mms_pkg::EE_LARGE_OFS}, mms_pkg::EE_LARGE_SIZE);
      end else begin
         hit_out[mms_pkg::SEL_EE] = eeon_in && in_win(addr_in,
            mms_pkg::EE_SMALL_BASE, mms_pkg::EE_SMALL_SIZE);
      end
      hit_out[mms_pkg::SEL_ROM] = rom_en_in &&
         in_win(addr_in, ROM_BASE, 17'h10000 - {1'b0, ROM_BASE});
      hit_out[mms_pkg::SEL_EXT] = 1'b1;
      // Lowest index wins, so a shadowed resource never sees the access
      sel_out = '0;
      for (int i = 0; i < mms_pkg::NUM_RES; i++) begin
         if (hit_out[i] && !found) begin
            sel_out[i] = 1'b1;
            found = 1'b1;
         end
      end
   end

endmodule : mms_decode

`default_nettype wire

// [hdl/mms_top.sv]
// Memory-map priority decoder and operating-mode latch
//
// Behaviour
// - Rank: registers, then RAM, then ROM
// - Overlap reaches only the higher-ranked resource
// - Boot ROM at BF00-BFFF only in special modes; enabled at reset in bootstrap
// - Expanded modes: ROM only if enable bit set
// - Single-chip, bootstrap: ROM always enabled
// - Small EEPROM fixed at B600, never moved
// - EEPROM reads take same cycles as ROM
// - Large EEPROM placed by 4-bit map field
// - Mode flags come from pins during reset
// - Pins ignored for mode after reset
// - Pin pairs map to the four modes
// - Pin A drives open-drain fetch strobe
// - Normal mode vectors from FFFA-FFFF
// - Special mode vectors from BFFA, test access
// - Priority field 0110; visibility bit set in test
// - Special flag is inverse B; A flag equals A
// - Cleared special flag can never be set
// - Mode-A flag written once in normal modes
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module mms_top #(
   parameter bit EE_LARGE = 1'b0,
   parameter logic [16:0] RAM_SIZE = mms_pkg::RAM_SIZE_DEF,
   parameter logic [15:0] ROM_BASE = mms_pkg::ROM_BASE_DEF
) (
   input wire logic clk_in,                      // 25 MHz clock
   input wire logic sys_rst_in,                  // Synchronous reset, high
   input wire logic [15:0] cpu_addr_in,          // Core address
   input wire logic cpu_valid_in,                // Core access this cycle
   input wire logic fetch_first_in,              // First E cycle of instruction
   input wire logic mode_pin_a_in,               // Mode pin A level
   input wire logic mode_pin_b_in,               // Mode pin B level
   input wire logic [7:0] config_nv_in,          // Stored startup configuration
   input wire logic [15:0] reg_addr_in,          // Register port address
   input wire logic [7:0] reg_wdata_in,          // Register write data
   input wire logic reg_wr_in,                   // Register write strobe
   input wire logic reg_rd_in,                   // Register read strobe
   output logic [7:0] reg_rdata_out,             // Read data, one cycle late
   output logic [mms_pkg::NUM_RES-1:0] sel_out,  // One-hot resource select
   output logic [15:0] vector_base_out,          // Reset vector table base
   output logic special_mode_flag_out,           // Special mode active
   output logic mode_a_flag_out,                 // Mode-A flag
   output logic boot_rom_enable_out,             // Boot ROM enable bit; in map only while special flag set
   output logic read_visibility_clock_off_out,   // Visibility / clock-off bit
   output logic [3:0] priority_select_out,       // Priority select field
   output logic instr_fetch_strobe_out,          // Fetch strobe pin value
   output logic instr_fetch_strobe_oe_n_out      // Fetch strobe drive, low drives
);

   // ******************************************************************
   // State
   // ******************************************************************
   typedef struct packed {
      logic pa_s1;
      logic pa_s2;
      logic pb_s1;
      logic pb_s2;
      logic boot_en;
      logic spec;
      logic mode_a;
      logic vis;
      logic [3:0] psel;
      logic mode_a_wr;
      logic vis_wr;
      logic [7:0] init;
      logic init_wr;
      logic [7:0] cfg;
      logic rom_act;
      logic [15:0] vec;
      logic [mms_pkg::NUM_RES-1:0] sel;
      logic [7:0] rdata;
      logic fetch_oe_n;
   } mms_state_type;

   mms_state_type s_r;
   mms_state_type s_nxt;
   logic [mms_pkg::NUM_RES-1:0] dec_hit;
   logic [mms_pkg::NUM_RES-1:0] dec_sel;

   // ******************************************************************
   // Decoder
   // ******************************************************************
   mms_decode #(
      .EE_LARGE(EE_LARGE),
      .RAM_SIZE(RAM_SIZE),
      .ROM_BASE(ROM_BASE)
   ) u_decode (
      .addr_in(cpu_addr_in),
      .ram_blk_in(s_r.init[mms_pkg::INIT_RAM_LSB +: 4]),
      .reg_blk_in(s_r.init[mms_pkg::INIT_REG_LSB +: 4]),
      .boot_en_in(s_r.boot_en && s_r.spec),
      .eeon_in(s_r.cfg[mms_pkg::CFG_EEON_BIT]),
      .rom_en_in(s_r.rom_act),
      .ee_map_in(s_r.cfg[mms_pkg::CFG_EE_LSB +: 4]),
      .hit_out(dec_hit),
      .sel_out(dec_sel)
   );

   // ******************************************************************
   // Next state
   // ******************************************************************
   always_comb begin
      s_nxt = s_r;
      // Pins are asynchronous: two flops before anything looks at them
      s_nxt.pa_s1 = mode_pin_a_in;
      s_nxt.pa_s2 = s_r.pa_s1;
      s_nxt.pb_s1 = mode_pin_b_in;
      s_nxt.pb_s2 = s_r.pb_s1;
      s_nxt.rdata = 8'h00;
      if (sys_rst_in) begin
         // Flags follow the pins for as long as reset is held
         s_nxt.boot_en = !s_r.pb_s2 && !s_r.pa_s2;
         s_nxt.spec = !s_r.pb_s2;
         s_nxt.mode_a = s_r.pa_s2;
         s_nxt.vis = !s_r.pb_s2 && s_r.pa_s2;
         s_nxt.psel = mms_pkg::PSEL_RST;
         s_nxt.mode_a_wr = 1'b0;
         s_nxt.vis_wr = 1'b0;
         s_nxt.init = mms_pkg::MAP_INIT_RST;
         s_nxt.init_wr = 1'b0;
         s_nxt.cfg = config_nv_in;
         s_nxt.rom_act = !s_r.pa_s2 || config_nv_in[mms_pkg::CFG_ROM_BIT];
         s_nxt.vec = s_r.pb_s2 ? mms_pkg::VEC_NORMAL : mms_pkg::VEC_SPECIAL;
         s_nxt.sel = '0;
         s_nxt.fetch_oe_n = 1'b1;
      end else begin
         // Pins no longer reach the flags here
         s_nxt.sel = cpu_valid_in ? dec_sel : '0;
         s_nxt.fetch_oe_n = !fetch_first_in;
         if (reg_rd_in) begin
            unique case (reg_addr_in)
               mms_pkg::PRIO_MISC_OFS: s_nxt.rdata = {s_r.boot_en, s_r.spec, s_r.mode_a,
                                                      s_r.vis, s_r.psel};
               mms_pkg::MAP_INIT_OFS: s_nxt.rdata = s_r.init;
               mms_pkg::CONFIG_OFS: s_nxt.rdata = s_r.cfg;
               default: s_nxt.rdata = 8'h00;
            endcase
         end
         if (reg_wr_in) begin
            unique case (reg_addr_in)
               mms_pkg::PRIO_MISC_OFS: begin
                  if (s_r.spec) begin
                     // Writing 0 here is final: only special mode can write it
                     s_nxt.boot_en = reg_wdata_in[mms_pkg::PM_BOOT_BIT];
                     s_nxt.spec = reg_wdata_in[mms_pkg::PM_SPEC_BIT];
                     s_nxt.mode_a = reg_wdata_in[mms_pkg::PM_MODE_A_BIT];
                  end else if (!s_r.mode_a_wr) begin
                     s_nxt.mode_a = reg_wdata_in[mms_pkg::PM_MODE_A_BIT];
                  end
                  s_nxt.mode_a_wr = 1'b1;
                  if (!s_r.vis_wr) begin
                     s_nxt.vis = reg_wdata_in[mms_pkg::PM_VIS_BIT];
                  end
                  s_nxt.vis_wr = 1'b1;
                  s_nxt.psel = reg_wdata_in[mms_pkg::PM_PSEL_LSB +: 4];
               end
               mms_pkg::MAP_INIT_OFS: begin
                  if (s_r.spec || !s_r.init_wr) begin
                     s_nxt.init = reg_wdata_in;
                  end
                  s_nxt.init_wr = 1'b1;
               end
               mms_pkg::CONFIG_OFS: begin
                  // Working latches; the stored copy only reloads at reset
                  if (s_r.spec) begin
                     s_nxt.cfg = reg_wdata_in;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge clk_in) begin
      s_r <= s_nxt;
   end

   // ******************************************************************
   // Outputs
   // ******************************************************************
   assign reg_rdata_out = s_r.rdata;
   assign sel_out = s_r.sel;
   assign vector_base_out = s_r.vec;
   assign special_mode_flag_out = s_r.spec;
   assign mode_a_flag_out = s_r.mode_a;
   assign boot_rom_enable_out = s_r.boot_en;
   assign read_visibility_clock_off_out = s_r.vis;
   assign priority_select_out = s_r.psel;
   // Open drain: the value is low whenever the pin is driven
   assign instr_fetch_strobe_out = s_r.fetch_oe_n;
   assign instr_fetch_strobe_oe_n_out = s_r.fetch_oe_n;

   // ******************************************************************
   // Checks
   // ******************************************************************
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   logic prio_wr;
   assign prio_wr = reg_wr_in && (reg_addr_in == mms_pkg::PRIO_MISC_OFS);

   sequence s_release;
      $fell(sys_rst_in);
   endsequence

   sequence s_latched_mode;
      (s_r.spec == !$past(s_r.pb_s2)) && (s_r.mode_a == $past(s_r.pa_s2));
   endsequence

   sequence s_fetch_cycle;
      fetch_first_in && !sys_rst_in;
   endsequence

   property p_mode_latch;
      s_release |-> s_latched_mode;
   endproperty

   property p_fetch_drive;
      s_fetch_cycle |=> !instr_fetch_strobe_oe_n_out && !instr_fetch_strobe_out;
   endproperty

   a_one_select: assert property (cpu_valid_in |=> $onehot(sel_out))
      else $error("access did not give exactly one select");
   a_reg_over_ram: assert property (
      cpu_valid_in && dec_hit[mms_pkg::SEL_REG] |=> sel_out[mms_pkg::SEL_REG])
      else $error("register block lost to a lower resource");
   a_ram_over_rom: assert property (
      cpu_valid_in && dec_hit[mms_pkg::SEL_RAM] && !dec_hit[mms_pkg::SEL_REG]
      |=> sel_out[mms_pkg::SEL_RAM] && !sel_out[mms_pkg::SEL_ROM])
      else $error("RAM overlap reached a lower resource");
   a_boot_gated: assert property (
      sel_out[mms_pkg::SEL_BOOT] |-> $past(s_r.boot_en && s_r.spec)
      && ($past(cpu_addr_in[15:8]) == mms_pkg::BOOT_BASE[15:8]))
      else $error("boot ROM selected outside bootstrap window");
   a_rom_enable: assert property (
      s_release |-> s_r.rom_act == (!$past(s_r.pa_s2)
      || $past(config_nv_in[mms_pkg::CFG_ROM_BIT])))
      else $error("ROM enable wrong for the latched mode");
   a_ee_fixed: assert property (
      !EE_LARGE && sel_out[mms_pkg::SEL_EE] |-> $past(cpu_addr_in[15:9])
      == mms_pkg::EE_SMALL_BASE[15:9])
      else $error("small EEPROM selected outside its window");
   a_ee_latency: assert property (
      cpu_valid_in && dec_sel[mms_pkg::SEL_EE] |=> sel_out[mms_pkg::SEL_EE])
      else $error("EEPROM select latency differs from ROM");
   a_ee_placed: assert property (
      EE_LARGE && sel_out[mms_pkg::SEL_EE] |-> $past(cpu_addr_in[15:11])
      == {$past(s_r.cfg[mms_pkg::CFG_EE_LSB +: 4]), 1'b1})
      else $error("large EEPROM selected outside mapped block");
   a_mode_latch: assert property (p_mode_latch)
      else $error("mode flags do not match pins at release");
   a_pins_ignored: assert property (
      !$past(sys_rst_in) && !$past(prio_wr) |-> $stable(s_r.spec) && $stable(s_r.mode_a))
      else $error("mode flags changed without a write");
   a_fetch_strobe: assert property (p_fetch_drive)
      else $error("fetch strobe not driven low");
   a_strobe_release: assert property (!fetch_first_in |=> instr_fetch_strobe_oe_n_out)
      else $error("fetch strobe driven outside fetch cycle");
   a_vector_base: assert property (
      s_release |-> vector_base_out == ($past(s_r.pb_s2) ? mms_pkg::VEC_NORMAL
      : mms_pkg::VEC_SPECIAL) && special_mode_flag_out == !$past(s_r.pb_s2))
      else $error("vector base wrong for mode pin B");
   a_prio_reset: assert property (
      s_release |-> priority_select_out == mms_pkg::PSEL_RST
      && read_visibility_clock_off_out == ($past(s_r.pa_s2) && !$past(s_r.pb_s2)))
      else $error("priority register reset value wrong");
   a_spec_no_set: assert property (!s_r.spec |=> !s_r.spec)
      else $error("special flag set again after clearing");
   a_mode_a_once: assert property (
      !s_r.spec && s_r.mode_a_wr |=> $stable(s_r.mode_a))
      else $error("mode-A flag accepted a second normal write");
   a_boot_release: assert property (
      s_release |-> boot_rom_enable_out == (!$past(s_r.pb_s2) && !$past(s_r.pa_s2)))
      else $error("boot ROM enable wrong for the latched mode");
   a_idle_select: assert property (!cpu_valid_in |=> sel_out == '0)
      else $error("select raised without an access");
   a_low_untouched: assert property (
      cpu_valid_in && dec_hit[mms_pkg::SEL_REG]
      |=> !sel_out[mms_pkg::SEL_RAM] && !sel_out[mms_pkg::SEL_ROM])
      else $error("shadowed resource selected under the register block");
   a_rom_held: assert property (
      !$past(sys_rst_in) |-> $stable(s_r.rom_act))
      else $error("ROM enable changed outside reset");
   a_vector_held: assert property (
      !$past(sys_rst_in) |-> $stable(vector_base_out))
      else $error("vector base changed outside reset");
   a_vis_once: assert property (
      !$past(sys_rst_in) && $past(s_r.vis_wr) |-> $stable(s_r.vis))
      else $error("visibility bit accepted a second write");
   a_mode_readback: assert property (
      reg_rd_in && (reg_addr_in == mms_pkg::PRIO_MISC_OFS)
      |=> reg_rdata_out[mms_pkg::PM_SPEC_BIT] == $past(s_r.spec))
      else $error("special flag read back wrong");

endmodule : mms_top

`default_nettype wire

// [test/mms_pin_board.sv]
// Far-side model: mode pin network sharing pin A with the fetch strobe
`timescale 1ns/10ps
`default_nettype none

module mms_pin_board (
   input wire logic pull_a_in,      // Board level on pin A when released
   input wire logic pull_b_in,      // Board level on pin B
   input wire logic strobe_in,      // Device fetch strobe value
   input wire logic strobe_oe_n_in, // Device drive, low drives
   output logic pin_a_out,          // Resolved pin A level
   output logic pin_b_out           // Resolved pin B level
);
   // Open drain: the device can only pull low, the resistor sets the rest
   assign pin_a_out = pull_a_in & (strobe_oe_n_in | strobe_in);
   assign pin_b_out = pull_b_in;
endmodule : mms_pin_board

`default_nettype wire

// [test/mms_top_tb.sv]
// Self-checking testbench for the memory-map decoder and mode latch
`timescale 1ns/10ps
`default_nettype none

module mms_top_tb;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [15:0] cpu_addr_in = 16'h0000;
   logic cpu_valid_in = 1'b0;
   logic fetch_first_in = 1'b0;
   logic pull_a = 1'b0;
   logic pull_b = 1'b1;
   logic pin_a;
   logic pin_b;
   logic [7:0] config_nv_in = 8'h03;
   logic [15:0] reg_addr_in = 16'h0000;
   logic [7:0] reg_wdata_in = 8'h00;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [7:0] reg_rdata_out;
   logic [mms_pkg::NUM_RES-1:0] sel_out;
   logic [15:0] vector_base_out;
   logic spec_flag, mode_a, boot, vis_bit, strobe, strobe_oe_n;
   logic [3:0] psel;
   int err_total = 0;
   int checked = 0;

   // ******************************************************************
   // Clock, design and pin network
   // ******************************************************************
   initial begin
      forever #20 clk_in = ~clk_in;
   end

   mms_top i_mms_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cpu_addr_in(cpu_addr_in),
      .cpu_valid_in(cpu_valid_in), .fetch_first_in(fetch_first_in), .mode_pin_a_in(pin_a),
      .mode_pin_b_in(pin_b), .config_nv_in(config_nv_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .sel_out(sel_out), .vector_base_out(vector_base_out),
      .special_mode_flag_out(spec_flag), .mode_a_flag_out(mode_a), .boot_rom_enable_out(boot),
      .read_visibility_clock_off_out(vis_bit), .priority_select_out(psel),
      .instr_fetch_strobe_out(strobe), .instr_fetch_strobe_oe_n_out(strobe_oe_n));

   mms_pin_board i_mms_pin_board (.pull_a_in(pull_a), .pull_b_in(pull_b),
      .strobe_in(strobe), .strobe_oe_n_in(strobe_oe_n), .pin_a_out(pin_a), .pin_b_out(pin_b));

   // ******************************************************************
   // Shared tasks
   // ******************************************************************
   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
         err_total++;
      end
   endtask : check_val

   task automatic check_sel(input logic [5:0] got, input logic [5:0] exp);
      checked++;
      if (got !== exp) begin
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
         err_total++;
      end
   endtask : check_sel

   task automatic do_reset(input logic b, input logic a, input logic [7:0] cfg);
      @(posedge clk_in);
      pull_b <= b;
      pull_a <= a;
      config_nv_in <= cfg;
      sys_rst_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_in);
      #1;
   endtask : do_reset

   task automatic access(input logic [15:0] a, input int idx);
      @(posedge clk_in);
      cpu_addr_in <= a;
      cpu_valid_in <= 1'b1;
      @(posedge clk_in);
      cpu_valid_in <= 1'b0;
      #1;
      check_sel(sel_out, 6'h01 << idx);
   endtask : access

   task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask : reg_wr

   task automatic reg_chk(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1;
      check_val({8'h00, reg_rdata_out}, {8'h00, exp});
   endtask : reg_chk

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop

   // ******************************************************************
   // Scenarios
   // ******************************************************************
   task automatic test_modes;
      logic b, a;
      logic [7:0] pm;
      for (int i = 0; i < 4; i++) begin
         b = i[1];
         a = i[0];
         pm = {~b & ~a, ~b, a, ~b & a, mms_pkg::PSEL_RST};
         do_reset(b, a, 8'h03);
         check_val({12'h000, boot, spec_flag, mode_a, vis_bit}, {12'h000, pm[7:4]});
         check_val({12'h000, psel}, {12'h000, mms_pkg::PSEL_RST});
         check_val(vector_base_out, b ? mms_pkg::VEC_NORMAL : mms_pkg::VEC_SPECIAL);
         reg_chk(mms_pkg::PRIO_MISC_OFS, pm);
         reg_chk(16'h1037, 8'h00);
      end
      $display("test modes done");
   endtask : test_modes

   task automatic test_pins_ignored;
      do_reset(1'b1, 1'b1, 8'h03);
      @(posedge clk_in);
      fetch_first_in <= 1'b1;
      @(posedge clk_in);
      fetch_first_in <= 1'b0;
      #1;
      check_val({14'h0, strobe_oe_n, strobe}, 16'h0000);
      @(posedge clk_in);
      #1;
      check_val({15'h0, strobe_oe_n}, 16'h0001);
      pull_a <= 1'b0;
      pull_b <= 1'b0;
      repeat (10) @(posedge clk_in);
      #1;
      check_val({14'h0, spec_flag, mode_a}, 16'h0001);
      check_val(vector_base_out, mms_pkg::VEC_NORMAL);
      $display("test pins_ignored done");
   endtask : test_pins_ignored

   task automatic test_decode_normal;
      logic [15:0] ad[12] = '{16'h103c, 16'h1040, 16'h01ff, 16'h0200, 16'hb5ff, 16'hb600,
         16'hb7ff, 16'hb800, 16'hbf00, 16'hcfff, 16'hd000, 16'hffff};
      int ix[12] = '{0, 5, 1, 5, 5, 3, 3, 5, 5, 5, 4, 4};
      do_reset(1'b1, 1'b0, 8'h03);
      for (int i = 0; i < 12; i++) begin
         access(ad[i], ix[i]);
      end
      do_reset(1'b1, 1'b1, 8'h00);
      access(16'hd000, mms_pkg::SEL_EXT);
      do_reset(1'b1, 1'b1, 8'h02);
      access(16'hfffe, mms_pkg::SEL_ROM);
      do_reset(1'b1, 1'b0, 8'h00);
      access(16'hd000, mms_pkg::SEL_ROM);
      access(16'hb600, mms_pkg::SEL_EXT);
      reg_wr(mms_pkg::MAP_INIT_OFS, 8'h11);
      access(16'h1040, mms_pkg::SEL_RAM);
      reg_wr(mms_pkg::MAP_INIT_OFS, 8'h01);
      access(16'h1040, mms_pkg::SEL_RAM);
      $display("test decode_normal done");
   endtask : test_decode_normal

   task automatic test_overlap;
      do_reset(1'b0, 1'b0, 8'h03);
      access(16'hbf00, mms_pkg::SEL_BOOT);
      access(16'hbfff, mms_pkg::SEL_BOOT);
      access(16'hbeff, mms_pkg::SEL_EXT);
      reg_wr(mms_pkg::MAP_INIT_OFS, 8'h11);
      access(16'h1000, mms_pkg::SEL_REG);
      access(16'h103f, mms_pkg::SEL_REG);
      access(16'h1040, mms_pkg::SEL_RAM);
      reg_wr(mms_pkg::MAP_INIT_OFS, 8'hd1);
      access(16'hd000, mms_pkg::SEL_RAM);
      access(16'hd1ff, mms_pkg::SEL_RAM);
      access(16'hd200, mms_pkg::SEL_ROM);
      reg_wr(mms_pkg::CONFIG_OFS, 8'hf1);
      access(16'hb600, mms_pkg::SEL_EE);
      access(16'hf800, mms_pkg::SEL_ROM);
      $display("test overlap done");
   endtask : test_overlap

   task automatic test_protect;
      do_reset(1'b0, 1'b0, 8'h03);
      reg_wr(mms_pkg::PRIO_MISC_OFS, 8'h06);
      reg_chk(mms_pkg::PRIO_MISC_OFS, 8'h06);
      reg_wr(mms_pkg::PRIO_MISC_OFS, 8'he7);
      reg_chk(mms_pkg::PRIO_MISC_OFS, 8'h07);
      check_val({14'h0, spec_flag, boot}, 16'h0000);
      do_reset(1'b1, 1'b0, 8'h03);
      reg_wr(mms_pkg::PRIO_MISC_OFS, 8'h25);
      reg_chk(mms_pkg::PRIO_MISC_OFS, 8'h25);
      reg_wr(mms_pkg::PRIO_MISC_OFS, 8'h13);
      reg_chk(mms_pkg::PRIO_MISC_OFS, 8'h23);
      check_val({15'h0, mode_a}, 16'h0001);
      do_reset(1'b0, 1'b1, 8'h03);
      reg_wr(mms_pkg::PRIO_MISC_OFS, 8'h46);
      reg_chk(mms_pkg::PRIO_MISC_OFS, 8'h46);
      reg_wr(mms_pkg::PRIO_MISC_OFS, 8'h66);
      reg_chk(mms_pkg::PRIO_MISC_OFS, 8'h66);
      $display("test protect done");
   endtask : test_protect

   // ******************************************************************
   // Sequence and watchdog
   // ******************************************************************
   initial begin
      test_modes();
      test_pins_ignored();
      test_decode_normal();
      test_overlap();
      test_protect();
      report_and_stop();
   end

   // Whole run is a few hundred cycles; this margin only catches hangs
   initial begin
      repeat (20000) @(posedge clk_in);
      err_total++;
      report_and_stop();
   end
endmodule : mms_top_tb

`default_nettype wire
